// ### hdl/dcfg_top.sv
// Top of the DAC de-pop, start-up and pin 1 configuration bank
//
// Local design decision: register access over Wishbone.
`timescale 1ns/10ps
module dcfg_top
    import dcfg_pkg::*;
#(
    // Cycles per millisecond; lower it to shorten every timed phase
    parameter int unsigned CYC_MS = CYC_PER_MS
)
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic             wb_ack_o,
    output logic [31:0]      wb_dat_o,
    // Start-up control
    input  wire logic        dac_start_i,
    input  wire logic        sel_clk_i,
    output logic [1:0]       int_res_sel_o,
    output logic [1:0]       mid_res_sel_o,
    output logic [3:0]       charge_time_o,
    output logic             cap_discharge_o,
    output logic             dac_power_en_o,
    output logic             charging_o,
    output logic             dac_ready_o,
    output logic             hard_reset_o,
    // Pin 1
    input  wire logic [15:0] pin1_src_i,
    input  wire logic        pin1_i,
    output logic             pin1_o,
    output logic             pin1_oe_o,
    output logic             pin1_pull_up_o,
    output logic             pin1_pull_dn_o
);
    // Charge time in milliseconds for each code
    function automatic int unsigned charge_ms(input logic [3:0] code);
        unique case (code)
            4'h0:    charge_ms = 2;
            4'h1:    charge_ms = 4;
            4'h2:    charge_ms = 8;
            4'h3:    charge_ms = 16;
            4'h4:    charge_ms = 50;
            4'h5:    charge_ms = 100;
            4'h6:    charge_ms = 250;
            4'h7:    charge_ms = 500;
            4'h8:    charge_ms = 1000;
            // Reserved codes fall back to the longest time
            default: charge_ms = 5000;
        endcase
    endfunction

    // Derived cycle counts
    localparam logic [31:0] DISCH_CYC = 32'(DISCHARGE_MS * CYC_MS);
    localparam logic [31:0] SHORT_CYC = 32'(DLY_SHORT_MS * CYC_MS);
    localparam logic [31:0] LONG_CYC  = 32'(DLY_LONG_MS * CYC_MS);
    localparam logic [31:0] LOSS_CYC  = 32'(CLK_LOSS_MS * CYC_MS);

    // All state of the bank
    typedef struct packed {
        logic [7:0]  depop;     // Resistors and charge time
        logic [7:0]  startup;   // Start-up control
        logic [7:0]  pin1;      // Pin function and drive
        logic [7:0]  pin1_out;  // General output value
        dcfg_seq_t   seq;       // Start-up sequence state
        logic [31:0] timer;     // Phase countdown
        logic        c1;        // Clock synchroniser stage 1
        logic        c2;        // Clock synchroniser stage 2
        logic        c3;        // Edge detect history
        logic [31:0] loss_cnt;  // Cycles since last clock edge
        logic        absent;    // Selected clock missing
        logic        hard_rst;  // Hard reset pulse
        logic        disch;     // Discharge output
        logic        pwr;       // Power enable output
        logic        chg;       // Charging output
        logic        ready;     // Sequence done
    } dcfg_st_t;

    dcfg_st_t    st_ff;
    dcfg_st_t    nxt_st;
    logic        clk_edge;      // Edge seen on selected clock
    logic        go_charge;     // Power-up now
    logic [31:0] dly_cyc;       // Chosen delay length
    logic [31:0] chg_cyc;       // Chosen charge length

    dcfg_bus_if  bus ();
    dcfg_pin_if  pin ();

    // Bus front end
    dcfg_wb_slave u_wb (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .cyc_i (wb_cyc_i),
        .stb_i (wb_stb_i),
        .we_i  (wb_we_i),
        .adr_i (wb_adr_i),
        .sel_i (wb_sel_i),
        .dat_i (wb_dat_i),
        .ack_o (wb_ack_o),
        .dat_o (wb_dat_o),
        .bus   (bus.slave)
    );

    // Pin function and drive
    dcfg_pin_drive u_pin (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .pin_i (pin1_i),
        .pin   (pin.pin)
    );

    // Configuration that the pin logic follows
    assign pin.func = st_ff.pin1[POS_FUNC +: 4];
    assign pin.drv  = st_ff.pin1[POS_DRV +: 3];
    assign pin.general_output  = st_ff.pin1_out[0];
    assign pin.src  = pin1_src_i;

    // Read mux; unmapped indexes read zero
    always_comb begin
        unique case (bus.idx)
            IDX_DEPOP:    bus.rdata = st_ff.depop;
            IDX_STARTUP:  bus.rdata = st_ff.startup;
            IDX_PIN1:     bus.rdata = st_ff.pin1;
            IDX_PIN1_OUT: bus.rdata = st_ff.pin1_out;
            IDX_STATUS:   bus.rdata = {pin.gin, st_ff.hard_rst,
                                       st_ff.absent, st_ff.seq};
            default:      bus.rdata = 8'h00;
        endcase
    end

    // Next state of registers, sequencer and clock watch
    always_comb begin
        nxt_st = st_ff;
        // Register writes
        if (bus.wr) begin
            unique case (bus.idx)
                IDX_DEPOP:    nxt_st.depop = bus.wdata;
                IDX_STARTUP:  nxt_st.startup = bus.wdata & MASK_STARTUP;
                IDX_PIN1:     nxt_st.pin1 = bus.wdata & MASK_PIN1;
                IDX_PIN1_OUT: nxt_st.pin1_out = bus.wdata & MASK_PIN1_OUT;
                // Status and unmapped indexes ignore writes
                default:      nxt_st.depop = st_ff.depop;
            endcase
        end

        // Clock watch; only the second and third stages feed the edge detect
        nxt_st.c1 = sel_clk_i;
        nxt_st.c2 = st_ff.c1;
        nxt_st.c3 = st_ff.c2;
        clk_edge  = st_ff.c2 ^ st_ff.c3;
        if (clk_edge) begin
            nxt_st.loss_cnt = 32'h00000000;
            nxt_st.absent   = 1'b0;
        end else if (st_ff.loss_cnt >= LOSS_CYC - 32'h00000001) begin
            nxt_st.loss_cnt = LOSS_CYC;
            nxt_st.absent   = 1'b1;
        end else begin
            nxt_st.loss_cnt = st_ff.loss_cnt + 32'h00000001;
        end

        dly_cyc = st_ff.startup[BIT_DLY_SEL] ? LONG_CYC : SHORT_CYC;
        chg_cyc = 32'(charge_ms(st_ff.depop[POS_CHARGE +: 4]) * CYC_MS);
        go_charge = 1'b0;

        // Start-up sequence
        unique case (st_ff.seq)
            ST_IDLE: begin
                if (dac_start_i) begin
                    if (st_ff.startup[BIT_DISCH]) begin
                        nxt_st.seq   = ST_DISCH;
                        nxt_st.timer = DISCH_CYC;
                    end else if (st_ff.startup[BIT_DLY_EN]) begin
                        nxt_st.seq   = ST_DELAY;
                        nxt_st.timer = dly_cyc;
                    end else begin
                        go_charge = 1'b1;
                    end
                end
            end
            ST_DISCH: begin
                if (st_ff.timer <= 32'h00000001) begin
                    if (st_ff.startup[BIT_DLY_EN]) begin
                        nxt_st.seq   = ST_DELAY;
                        nxt_st.timer = dly_cyc;
                    end else begin
                        go_charge = 1'b1;
                    end
                end else begin
                    nxt_st.timer = st_ff.timer - 32'h00000001;
                end
            end
            ST_DELAY: begin
                if (st_ff.timer <= 32'h00000001) begin
                    go_charge = 1'b1;
                end else begin
                    nxt_st.timer = st_ff.timer - 32'h00000001;
                end
            end
            ST_CHARGE: begin
                if (st_ff.timer <= 32'h00000001) begin
                    nxt_st.seq = ST_ON;
                end else begin
                    nxt_st.timer = st_ff.timer - 32'h00000001;
                end
            end
            ST_ON: begin
                nxt_st.seq = ST_ON;
            end
            // Recover from a corrupted code
            default: begin
                nxt_st.seq = ST_IDLE;
            end
        endcase

        // Power-up and charge start together
        if (go_charge) begin
            nxt_st.seq   = ST_CHARGE;
            nxt_st.timer = chg_cyc;
        end

        // Dropping the start request powers the DAC down at once
        if (!dac_start_i) begin
            nxt_st.seq   = ST_IDLE;
            nxt_st.timer = 32'h00000000;
        end

        // Registered sequence outputs follow the next state
        nxt_st.disch = (nxt_st.seq == ST_DISCH);
        nxt_st.chg   = (nxt_st.seq == ST_CHARGE);
        nxt_st.pwr   = (nxt_st.seq == ST_CHARGE) | (nxt_st.seq == ST_ON);
        nxt_st.ready = (nxt_st.seq == ST_ON);
        nxt_st.hard_rst = 1'b0;

        if (st_ff.startup[BIT_LOSS_EN] && st_ff.absent) begin
            // The hard reset clears this bank too, so it is one pulse
            nxt_st.hard_rst = 1'b1;
            nxt_st.depop    = RST_DEPOP;
            nxt_st.startup  = RST_STARTUP;
            nxt_st.pin1     = RST_PIN1;
            nxt_st.pin1_out = RST_PIN1_OUT;
            nxt_st.seq      = ST_IDLE;
            nxt_st.timer    = 32'h00000000;
            nxt_st.disch    = 1'b0;
            nxt_st.chg      = 1'b0;
            nxt_st.pwr      = 1'b0;
            nxt_st.ready    = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff.depop    <= RST_DEPOP;
            st_ff.startup  <= RST_STARTUP;
            st_ff.pin1     <= RST_PIN1;
            st_ff.pin1_out <= RST_PIN1_OUT;
            st_ff.seq      <= ST_IDLE;
            st_ff.timer    <= 32'h00000000;
            st_ff.c1       <= 1'b0;
            st_ff.c2       <= 1'b0;
            st_ff.c3       <= 1'b0;
            st_ff.loss_cnt <= 32'h00000000;
            st_ff.absent   <= 1'b0;
            st_ff.hard_rst <= 1'b0;
            st_ff.disch    <= 1'b0;
            st_ff.pwr      <= 1'b0;
            st_ff.chg      <= 1'b0;
            st_ff.ready    <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs, each straight from a flip-flop
    assign int_res_sel_o   = st_ff.depop[POS_INT_RES +: 2];
    assign mid_res_sel_o   = st_ff.depop[POS_MID_RES +: 2];
    assign charge_time_o   = st_ff.depop[POS_CHARGE +: 4];
    assign cap_discharge_o = st_ff.disch;
    assign dac_power_en_o  = st_ff.pwr;
    assign charging_o      = st_ff.chg;
    assign dac_ready_o     = st_ff.ready;
    assign hard_reset_o    = st_ff.hard_rst;
    assign pin1_o          = pin.pin_o;
    assign pin1_oe_o       = pin.pin_oe;
    assign pin1_pull_up_o  = pin.pull_up;
    assign pin1_pull_dn_o  = pin.pull_dn;
endmodule

// ### hdl/dcfg_pkg.sv
// Register map, field layout, timing and types of the DAC config bank
// Functional notes
// - Two resistor fields, shared code, resets 0/3
// - Charge time codes 0-8, reserved above, reset 5
// - Bit 7 runs capacitor discharge at start
// - Bit 6 delays DAC power-up
// - Bit 5 picks short or long delay
// - Bit 4 hard reset after 2ms clock loss
// - Pin function codes 0-4 in bits 7-4
// - Pin function codes 5-13 except 11 route serial outputs
// - Pin register resets to 0x32, interrupt output
// - Drive field bits 2-0, ignored for serial
// - Drive codes 1-5 pick low/high strength
package dcfg_pkg;
    // Clock rate and the cycles in one millisecond
    localparam int unsigned CLK_HZ     = 20_000_000;
    localparam int unsigned MS_PER_S   = 1000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
    // Register indexes; byte address is four times the index
    localparam logic [5:0] IDX_DEPOP    = 6'h06;
    localparam logic [5:0] IDX_STARTUP  = 6'h07;
    localparam logic [5:0] IDX_PIN1     = 6'h0A;
    localparam logic [5:0] IDX_PIN1_OUT = 6'h0D;
    localparam logic [5:0] IDX_STATUS   = 6'h0E;
    // Reset values
    localparam logic [7:0] RST_DEPOP    = 8'h35;
    localparam logic [7:0] RST_STARTUP  = 8'h00;
    localparam logic [7:0] RST_PIN1     = 8'h32;
    localparam logic [7:0] RST_PIN1_OUT = 8'h00;
    // Writable bits; the rest read as zero
    localparam logic [7:0] MASK_STARTUP = 8'hF0;
    localparam logic [7:0] MASK_PIN1    = 8'hF7;
    localparam logic [7:0] MASK_PIN1_OUT = 8'h01;
    // Field positions
    localparam int unsigned POS_INT_RES = 6;
    localparam int unsigned POS_MID_RES = 4;
    localparam int unsigned POS_CHARGE  = 0;
    localparam int unsigned BIT_DISCH   = 7;
    localparam int unsigned BIT_DLY_EN  = 6;
    localparam int unsigned BIT_DLY_SEL = 5;
    localparam int unsigned BIT_LOSS_EN = 4;
    localparam int unsigned POS_FUNC    = 4;
    localparam int unsigned POS_DRV     = 0;
    // Timing in milliseconds
    localparam int unsigned DISCHARGE_MS = 2;
    localparam int unsigned DLY_SHORT_MS = 64;
    localparam int unsigned DLY_LONG_MS  = 256;
    localparam int unsigned CLK_LOSS_MS  = 2;
    // Pin function codes that the pin logic decodes
    localparam logic [3:0] FN_OFF   = 4'h0;
    localparam logic [3:0] FN_INPUT = 4'h1;
    localparam logic [3:0] FN_GPO   = 4'h2;
    localparam logic [3:0] FN_CLK   = 4'hB;
    localparam logic [3:0] FN_LAST  = 4'hD;
    // Drive codes
    localparam logic [2:0] DRV_HIZ  = 3'h0;
    localparam logic [2:0] DRV_PP   = 3'h1;
    localparam logic [2:0] DRV_LWH  = 3'h2;
    localparam logic [2:0] DRV_LZ   = 3'h3;
    localparam logic [2:0] DRV_WLH  = 3'h4;
    localparam logic [2:0] DRV_ZH   = 3'h5;
    // Start-up sequence states
    typedef enum logic [4:0] {
        ST_IDLE   = 5'h01,
        ST_DISCH  = 5'h02,
        ST_DELAY  = 5'h04,
        ST_CHARGE = 5'h08,
        ST_ON     = 5'h10
    } dcfg_seq_t;
endpackage

// ### hdl/dcfg_if.sv
// Interfaces between the bank top and its bus and pin modules
`timescale 1ns/10ps
interface dcfg_bus_if;
    logic       wr;     // One-cycle write strobe
    logic [5:0] idx;    // Word index
    logic [7:0] wdata;  // Write byte
    logic [7:0] rdata;  // Read byte from the bank
    modport slave (output wr, output idx, output wdata, input rdata);
    modport bank  (input wr, input idx, input wdata, output rdata);
endinterface

interface dcfg_pin_if;
    logic [3:0]  func;     // Pin function code
    logic [2:0]  drv;      // Drive code
    logic        general_output;      // General output value
    logic [15:0] src;      // Source per function code
    logic        pin_o;    // Pin output value
    logic        pin_oe;   // Pin output enable
    logic        pull_up;  // Weak high
    logic        pull_dn;  // Weak low
    logic        gin;      // Synchronised pin level
    modport bank (output func, output drv, output general_output, output src,
                  input pin_o, input pin_oe, input pull_up,
                  input pull_dn, input gin);
    modport pin  (input func, input drv, input general_output, input src,
                  output pin_o, output pin_oe, output pull_up,
                  output pull_dn, output gin);
endinterface

// ### hdl/dcfg_wb_slave.sv
// Classic Wishbone slave front end of the config bank
`timescale 1ns/10ps
module dcfg_wb_slave
    import dcfg_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic             ack_o,
    output logic [31:0]      dat_o,
    dcfg_bus_if.slave        bus
);
    typedef struct packed {
        logic        ack;  // Answer, one cycle
        logic [31:0] dat;  // Captured read word
    } dcfg_wb_st_t;

    dcfg_wb_st_t st_ff;
    dcfg_wb_st_t nxt_st;
    logic        take;     // Request taken this edge

    // Every request answers one cycle later; ack drops after one cycle
    always_comb begin
        take        = cyc_i & stb_i & ~st_ff.ack;
        nxt_st      = st_ff;
        nxt_st.ack  = take;
        bus.idx     = adr_i[7:2];
        bus.wdata   = dat_i[7:0];
        // Write lands at the edge where the master samples ack high,
        // so a master that holds its request sees exactly one write
        // Only the low lane holds data; other lanes are ignored
        bus.wr      = cyc_i & stb_i & st_ff.ack & we_i & sel_i[0];
        if (take) begin
            nxt_st.dat = {24'h000000, bus.rdata};
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign ack_o = st_ff.ack;
    assign dat_o = st_ff.dat;
endmodule

// ### hdl/dcfg_pin_drive.sv
// Function mux and drive strength logic of pin 1
`timescale 1ns/10ps
module dcfg_pin_drive
    import dcfg_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic pin_i,
    dcfg_pin_if.pin   pin
);
    typedef struct packed {
        logic s1;   // Synchroniser first stage
        logic s2;   // Synchronised level
        logic o;
        logic oe;
        logic pu;
        logic pd;
    } dcfg_pin_st_t;

    dcfg_pin_st_t st_ff;
    dcfg_pin_st_t nxt_st;
    logic         val;     // Selected source value
    logic         serial;  // Serial audio output selected

    // Pick source and apply drive; all pin outputs are registered
    always_comb begin
        nxt_st    = st_ff;
        nxt_st.s1 = pin_i;
        nxt_st.s2 = st_ff.s1;
        val       = (pin.func == FN_GPO) ? pin.general_output : pin.src[pin.func];
        serial    = (pin.func > FN_GPO + 4'h2) && (pin.func <= FN_LAST)
                    && (pin.func != FN_CLK);
        nxt_st.o  = 1'b0;
        nxt_st.oe = 1'b0;
        nxt_st.pu = 1'b0;
        nxt_st.pd = 1'b0;
        if (pin.func == FN_OFF || pin.func == FN_INPUT
            || pin.func > FN_LAST) begin
            nxt_st.oe = 1'b0;
        end else if (serial) begin
            nxt_st.o  = val;
            nxt_st.oe = 1'b1;
        end else begin
            unique case (pin.drv)
                DRV_PP: begin
                    nxt_st.o  = val;
                    nxt_st.oe = 1'b1;
                end
                DRV_LWH: begin
                    nxt_st.oe = ~val;
                    nxt_st.pu = val;
                end
                DRV_LZ: begin
                    nxt_st.oe = ~val;
                end
                DRV_WLH: begin
                    nxt_st.o  = 1'b1;
                    nxt_st.oe = val;
                    nxt_st.pd = ~val;
                end
                DRV_ZH: begin
                    nxt_st.o  = 1'b1;
                    nxt_st.oe = val;
                end
                // Hi-Z and reserved codes leave the pin released
                default: begin
                    nxt_st.oe = 1'b0;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pin.pin_o   = st_ff.o;
    assign pin.pin_oe  = st_ff.oe;
    assign pin.pull_up = st_ff.pu;
    assign pin.pull_dn = st_ff.pd;
    assign pin.gin     = st_ff.s2;
endmodule

// ### tb/dcfg_top_sva.sv
// Port-level concurrent checks of the DAC config bank top
`timescale 1ns/10ps
module dcfg_top_sva
    import dcfg_pkg::*;
#(
    parameter int unsigned CYC_MS = CYC_PER_MS
)
(
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       dac_start_i,
    input wire logic [1:0] int_res_sel_o,
    input wire logic [1:0] mid_res_sel_o,
    input wire logic [3:0] charge_time_o,
    input wire logic       cap_discharge_o,
    input wire logic       dac_power_en_o,
    input wire logic       charging_o,
    input wire logic       dac_ready_o,
    input wire logic       hard_reset_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_res_reset;
        $past(rst_i) |-> int_res_sel_o == 2'h0 && mid_res_sel_o == 2'h3;
    endproperty
    a_res_reset: assert property (p_res_reset)
        else $error("resistor fields wrong after reset");
    property p_chg_reset;
        $past(rst_i) |-> charge_time_o == 4'h5;
    endproperty
    a_chg_reset: assert property (p_chg_reset)
        else $error("charge time wrong after reset");
    property p_disch;
        cap_discharge_o |-> !dac_power_en_o && !charging_o;
    endproperty
    a_disch: assert property (p_disch)
        else $error("power on during discharge");
    property p_pwr_rise;
        $rose(dac_power_en_o) |-> charging_o && !dac_ready_o;
    endproperty
    a_pwr_rise: assert property (p_pwr_rise)
        else $error("power-up did not begin with charging");
    property p_stop;
        !dac_start_i |=> !dac_power_en_o && !cap_discharge_o && !dac_ready_o;
    endproperty
    a_stop: assert property (p_stop)
        else $error("sequence kept running after start dropped");
    property p_ready;
        dac_ready_o |-> dac_power_en_o && !charging_o;
    endproperty
    a_ready: assert property (p_ready)
        else $error("ready while charging or unpowered");
    property p_hard_pulse;
        hard_reset_o |=> !hard_reset_o;
    endproperty
    a_hard_pulse: assert property (p_hard_pulse)
        else $error("hard reset longer than one cycle");
    property p_hard_regs;
        hard_reset_o |-> ##[0:2]
            (charge_time_o == 4'h5 && mid_res_sel_o == 2'h3);
    endproperty
    a_hard_regs: assert property (p_hard_regs)
        else $error("fields not restored by hard reset");
endmodule

bind dcfg_top dcfg_top_sva #(.CYC_MS(CYC_MS)) i_sva (
    .clk_i(clk_i), .rst_i(rst_i), .dac_start_i(dac_start_i),
    .int_res_sel_o(int_res_sel_o), .mid_res_sel_o(mid_res_sel_o),
    .charge_time_o(charge_time_o), .cap_discharge_o(cap_discharge_o),
    .dac_power_en_o(dac_power_en_o), .charging_o(charging_o),
    .dac_ready_o(dac_ready_o), .hard_reset_o(hard_reset_o));

// ### tb/test_dcfg_top.sv
// Self-checking bench for the DAC config bank
`timescale 1ns/10ps
module test_dcfg_top
    import dcfg_pkg::*;
;
    localparam int unsigned MS = 10;  // Short millisecond keeps run brief
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic        ack;
    logic [31:0] rdat, got;
    logic        start = 1'b0, sclk = 1'b0, run = 1'b1;
    logic [15:0] src = 16'h0020;  // Only serial code 5 sources a one
    logic [1:0]  ires, mres;
    logic [3:0]  ctime;
    logic        disch, pwr, chg, rdy, hrst, p_o, p_oe, pu, pd;
    int          error_cnt = 0;
    int          n_compared = 0;

    dcfg_top #(.CYC_MS(MS)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
        .wb_ack_o(ack), .wb_dat_o(rdat), .dac_start_i(start),
        .sel_clk_i(sclk), .int_res_sel_o(ires), .mid_res_sel_o(mres),
        .charge_time_o(ctime), .cap_discharge_o(disch),
        .dac_power_en_o(pwr), .charging_o(chg), .dac_ready_o(rdy),
        .hard_reset_o(hrst), .pin1_src_i(src), .pin1_i(1'b1),
        .pin1_o(p_o), .pin1_oe_o(p_oe), .pin1_pull_up_o(pu),
        .pin1_pull_dn_o(pd));

    // Clock and a selected clock that stops when run drops
    always #25 clk_i = ~clk_i;
    always @(posedge clk_i) if (run) sclk <= ~sclk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    // One classic cycle; waits for ack, never a fixed count
    task automatic wb(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        // Only the watchdog ends a wait that never sees ack
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        got = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        wb(a, 1'b0, 32'h0);
        check(got, exp);
    endtask
    function automatic logic pick(input int k);
        case (k)
            0: return rdy;
            1: return chg;
            default: return hrst;
        endcase
    endfunction
    // Bounded wait; the cycle count must land in lo..hi
    task automatic wait_hi(input int k, input int lo, input int hi);
        int n;
        n = 0;
        while (pick(k) !== 1'b1 && n < 4000) begin
            @(posedge clk_i);
            n++;
        end
        check(32'(n >= lo && n <= hi), 32'h1);
    endtask
    task automatic go(input logic [7:0] cfg);
        wb(8'h1C, 1'b1, 32'(cfg));
        @(posedge clk_i);
        start <= 1'b1;
        repeat (2) @(posedge clk_i);
    endtask
    task automatic wrap_up;
        if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // Watchdog well beyond the longest expected run
    initial begin
        #(10000 * 50);
        error_cnt++;
        wrap_up;
    end

    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h18, 32'h35);
        rd(8'h1C, 32'h00);
        rd(8'h28, 32'h32);
        wb(8'h1C, 1'b1, 32'hFF);
        rd(8'h1C, 32'hF0);
        wb(8'h28, 1'b1, 32'hFF);
        rd(8'h28, 32'hF7);
        wb(8'h3C, 1'b1, 32'hFF);
        rd(8'h3C, 32'h00);
        // Shortest charge code, no discharge, no delay
        wb(8'h18, 1'b1, 32'hB0);
        go(8'h00);
        check(32'({ires, mres, ctime}), 32'hB0);
        check(32'({pwr, chg, disch}), 32'h6);
        wait_hi(0, 2 * MS - 2, 2 * MS + 3);
        start <= 1'b0;
        go(8'h80);
        check(32'(disch), 32'h1);
        wait_hi(1, DISCHARGE_MS * MS - 2, DISCHARGE_MS * MS + 3);
        start <= 1'b0;
        go(8'h40);
        check(32'({pwr, chg, disch}), 32'h0);
        wait_hi(1, DLY_SHORT_MS * MS - 2, DLY_SHORT_MS * MS + 3);
        start <= 1'b0;
        go(8'h60);
        wait_hi(1, DLY_LONG_MS * MS - 2, DLY_LONG_MS * MS + 3);
        start <= 1'b0;
        // Clock loss with reset enabled restores every register
        wb(8'h1C, 1'b1, 32'h10);
        wb(8'h18, 1'b1, 32'h00);
        run <= 1'b0;
        wait_hi(2, CLK_LOSS_MS * MS - 2, CLK_LOSS_MS * MS + 6);
        run <= 1'b1;
        rd(8'h18, 32'h35);
        rd(8'h1C, 32'h00);
        rd(8'h38, 32'h81);
        // Pin 1 function and drive
        wb(8'h34, 1'b1, 32'h01);
        wb(8'h28, 1'b1, 32'h21);
        repeat (2) @(posedge clk_i);
        check(32'({p_o, p_oe}), 32'h3);
        wb(8'h28, 1'b1, 32'h20);
        repeat (2) @(posedge clk_i);
        check(32'(p_oe), 32'h0);
        wb(8'h28, 1'b1, 32'h50);
        repeat (2) @(posedge clk_i);
        check(32'({p_o, p_oe}), 32'h3);
        wb(8'h28, 1'b1, 32'h23);
        repeat (2) @(posedge clk_i);
        check(32'(p_oe), 32'h0);
        wb(8'h34, 1'b1, 32'h00);
        repeat (2) @(posedge clk_i);
        check(32'({p_o, p_oe}), 32'h1);
        // Weak low of drive code 4 at value 0, then weak high of drive code 2 at value 1
        wb(8'h28, 1'b1, 32'h24);
        repeat (2) @(posedge clk_i);
        check(32'({pd, p_o, p_oe}), 32'h6);
        wb(8'h34, 1'b1, 32'h01);
        wb(8'h28, 1'b1, 32'h22);
        repeat (2) @(posedge clk_i);
        check(32'({pu, p_o, p_oe}), 32'h4);
        wrap_up;
    end
endmodule
